/* File: slf_pkg.sv */
/*
  Package for the security lockout and fuse logic: counter codes, fuse bit
  positions, access-area codes and reset values.
  Assumes one clock domain; the nonvolatile store that holds counters and
  fuses across power cycles sits outside and is loaded by the host side.
*/
// Overview of operation
// - Sixteen 8-bit password failure counters step FF, EE, CC, 88, 00 on failures.
// - A password whose counter holds 00 is refused forever.
// - Correct password while counter above 00 restores it to FF.
// - Four 8-bit key-set failure counters step FF, EE, CC, 88, 00 on failures.
// - A key set whose counter holds 00 can never authenticate again.
// - Successful authentication while counter above 00 reloads it to FF.
// - Fuse status byte: factory bit3, personalization bit2, maker bit1, fab bit0.
// - Fuses are one-way; once blown nothing restores them.
// - Fuses blow in order fab, maker code, personalization; others are rejected.
// - Fab locks reset answer and fab code; maker locks maker code; pers freezes rest except test area and password areas.
// - Factory fuse makes the lot history code permanently read-only.
// - Before personalization lock, config writes except the test area, and reads of seeds, session keys and passwords, need write password set 7.
// - After personalization lock, seeds, session keys, forbidden region are denied.
// - User zone rights come only from zone access settings, never fuses.
// - The 64-bit reset answer register is writable until the fab fuse is blown.
// - After personalization lock, a set's write password allows changing its passwords and its counter.
// - After personalization lock, set 7 no longer grants configuration writes.
package slf_pkg;
   localparam int NUM_PW = 16;
   localparam int NUM_KEY = 4;
   localparam logic [7:0] CNT_FULL = 8'hff;
   localparam logic [7:0] CNT_ONE = 8'hee;
   localparam logic [7:0] CNT_TWO = 8'hcc;
   localparam logic [7:0] CNT_THREE = 8'h88;
   localparam logic [7:0] CNT_LOCKED = 8'h00;
   localparam int FUSE_FAB = 0;
   localparam int FUSE_MAKER = 1;
   localparam int FUSE_PERS = 2;
   localparam int FUSE_FACTORY = 3;
   localparam logic [3:0] FUSE_RESET = 4'hf;
   localparam logic [3:0] FUSE_RESV = 4'hf;
   localparam logic [2:0] SECURE_SET = 3'h7;
   // Configuration area codes
   localparam logic [3:0] AREA_IDENT = 4'h0;
   localparam logic [3:0] AREA_TEST = 4'h1;
   localparam logic [3:0] AREA_MAKER = 4'h2;
   localparam logic [3:0] AREA_LOT = 4'h3;
   localparam logic [3:0] AREA_ACCESS = 4'h4;
   localparam logic [3:0] AREA_CRYPTO = 4'h5;
   localparam logic [3:0] AREA_SESSION = 4'h6;
   localparam logic [3:0] AREA_SECRET = 4'h7;
   localparam logic [3:0] AREA_PASSWORD = 4'h8;
   localparam logic [3:0] AREA_PW_CNT = 4'h9;
   localparam logic [3:0] AREA_FORBID = 4'ha;
   localparam logic [3:0] AREA_USER = 4'hb;
   localparam logic [3:0] AREA_RESET_ANS = 4'hc;
endpackage

/* File: slf_fail_counter.sv */
/*
  One attempt counter stepping FF, EE, CC, 88, 00 on failures.
  Assumes fail and pass are single-cycle and never both high.
*/
`timescale 1ns/1ps
module slf_fail_counter (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Nonvolatile preload
   input wire logic load,
   input wire logic [7:0] load_value,
   // Attempt outcome
   input wire logic fail,
   input wire logic pass,
   // State
   output logic [7:0] count
);
   logic [7:0] next_count;

   always_comb begin
      next_count = count;
      if (load) begin
         next_count = load_value;
      end else if (count != slf_pkg::CNT_LOCKED) begin
         if (pass) begin
            next_count = slf_pkg::CNT_FULL;
         end else if (fail) begin
            case (count)
               slf_pkg::CNT_FULL: next_count = slf_pkg::CNT_ONE;
               slf_pkg::CNT_ONE: next_count = slf_pkg::CNT_TWO;
               slf_pkg::CNT_TWO: next_count = slf_pkg::CNT_THREE;
               default: next_count = slf_pkg::CNT_LOCKED;
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         count <= slf_pkg::CNT_FULL;
      end else begin
         count <= next_count;
      end
   end
endmodule

/* File: slf_security_core.sv */
/*
  Security state: password and key attempt counters, one-way fuses and the
  access decision for configuration areas and user zones.
  Assumes command decoding and the credential comparison happen outside; this
  block gets one-cycle verify results and an access query each cycle.
*/
`timescale 1ns/1ps
module slf_security_core (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Nonvolatile preload of counters and fuses
   input wire logic nv_load,
   input wire logic [3:0] nv_fuses,
   input wire logic [8*16-1:0] nv_pw_counts,
   input wire logic [8*4-1:0] nv_key_counts,
   // Password verification
   input wire logic pw_verify,
   input wire logic [3:0] pw_index,
   input wire logic pw_match,
   // Authentication
   input wire logic auth_verify,
   input wire logic [1:0] auth_key,
   input wire logic auth_match,
   // Fuse blow request
   input wire logic fuse_req,
   input wire logic [1:0] fuse_id,
   // Access query
   input wire logic [3:0] acc_area,
   input wire logic [2:0] acc_pw_set,
   input wire logic acc_zone_read_ok,
   input wire logic acc_zone_write_ok,
   // Results
   output logic pw_refused,
   output logic auth_refused,
   output logic fuse_done,
   output logic fuse_rejected,
   output logic [7:0] security_fuse_status,
   output logic [7:0] password_fail_counter [16],
   output logic [7:0] auth_fail_counter [4],
   output logic read_grant,
   output logic write_grant
);
   logic [3:0] fuses;
   logic [3:0] next_fuses;
   logic [7:0] wpw_ok;
   logic [7:0] next_wpw_ok;
   logic next_pw_refused;
   logic next_auth_refused;
   logic next_fuse_done;
   logic next_fuse_rejected;
   logic next_read_grant;
   logic next_write_grant;
   logic [7:0] pw_cnt [16];
   logic [7:0] key_cnt [4];
   logic pw_open;
   logic key_open;

   ////////////////////////////////////////////////////////////////////////////
   // Attempt counters
   assign pw_open = (pw_cnt[pw_index] != slf_pkg::CNT_LOCKED);
   assign key_open = (key_cnt[auth_key] != slf_pkg::CNT_LOCKED);

   for (genvar i = 0; i < slf_pkg::NUM_PW; i++) begin : g_pw
      slf_fail_counter u_cnt (
         .sys_clk(sys_clk),
         .sys_rst(sys_rst),
         .load(nv_load),
         .load_value(nv_pw_counts[8*i +: 8]),
         .fail(pw_verify && pw_index == 4'(i) && !pw_match),
         .pass(pw_verify && pw_index == 4'(i) && pw_match),
         .count(pw_cnt[i])
      );
   end

   for (genvar k = 0; k < slf_pkg::NUM_KEY; k++) begin : g_key
      slf_fail_counter u_cnt (
         .sys_clk(sys_clk),
         .sys_rst(sys_rst),
         .load(nv_load),
         .load_value(nv_key_counts[8*k +: 8]),
         .fail(auth_verify && auth_key == 2'(k) && !auth_match),
         .pass(auth_verify && auth_key == 2'(k) && auth_match),
         .count(key_cnt[k])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fuses and verified write passwords
   always_comb begin
      next_fuses = fuses;
      next_wpw_ok = wpw_ok;
      next_fuse_done = 1'b0;
      next_fuse_rejected = 1'b0;
      next_pw_refused = pw_verify && !pw_open;
      next_auth_refused = auth_verify && !key_open;
      if (nv_load) begin
         next_fuses = fuses & nv_fuses;
         next_wpw_ok = 8'h00;
      end else if (pw_verify && pw_index[3] == 1'b0) begin
         next_wpw_ok[pw_index[2:0]] = pw_open && pw_match;
      end
      if (fuse_req) begin
         case (fuse_id)
            2'(slf_pkg::FUSE_FAB): next_fuse_done = fuses[slf_pkg::FUSE_FAB];
            2'(slf_pkg::FUSE_MAKER):
               next_fuse_done = !fuses[slf_pkg::FUSE_FAB] && fuses[slf_pkg::FUSE_MAKER];
            2'(slf_pkg::FUSE_PERS):
               next_fuse_done = !fuses[slf_pkg::FUSE_MAKER] && fuses[slf_pkg::FUSE_PERS];
            default: next_fuse_done = 1'b0;
         endcase
         next_fuse_rejected = !next_fuse_done;
         if (next_fuse_done) begin
            next_fuses[fuse_id] = 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Access decision
   always_comb begin
      logic pers;
      logic secure;
      logic own_pw;
      pers = !fuses[slf_pkg::FUSE_PERS];
      secure = !pers && wpw_ok[slf_pkg::SECURE_SET];
      own_pw = wpw_ok[acc_pw_set];
      next_read_grant = 1'b1;
      next_write_grant = 1'b0;
      case (acc_area)
         slf_pkg::AREA_IDENT: next_write_grant = secure && fuses[slf_pkg::FUSE_FAB];
         slf_pkg::AREA_RESET_ANS:
            next_write_grant = secure && fuses[slf_pkg::FUSE_FAB];
         slf_pkg::AREA_TEST: next_write_grant = 1'b1;
         slf_pkg::AREA_MAKER: next_write_grant = secure && fuses[slf_pkg::FUSE_MAKER];
         slf_pkg::AREA_LOT: next_write_grant = fuses[slf_pkg::FUSE_FACTORY] && secure;
         slf_pkg::AREA_ACCESS, slf_pkg::AREA_CRYPTO: next_write_grant = secure;
         slf_pkg::AREA_SESSION, slf_pkg::AREA_SECRET: begin
            next_read_grant = secure;
            next_write_grant = secure;
         end
         slf_pkg::AREA_PASSWORD: begin
            next_read_grant = pers ? own_pw : secure;
            next_write_grant = pers ? own_pw : secure;
         end
         slf_pkg::AREA_PW_CNT: next_write_grant = pers ? own_pw : secure;
         slf_pkg::AREA_USER: begin
            next_read_grant = acc_zone_read_ok;
            next_write_grant = acc_zone_write_ok;
         end
         default: begin
            next_read_grant = 1'b0;
            next_write_grant = 1'b0;
         end
      endcase
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         fuses <= slf_pkg::FUSE_RESET;
         wpw_ok <= 8'h00;
         pw_refused <= 1'b0;
         auth_refused <= 1'b0;
         fuse_done <= 1'b0;
         fuse_rejected <= 1'b0;
         read_grant <= 1'b0;
         write_grant <= 1'b0;
         security_fuse_status <= {slf_pkg::FUSE_RESV, slf_pkg::FUSE_RESET};
      end else begin
         fuses <= next_fuses;
         wpw_ok <= next_wpw_ok;
         pw_refused <= next_pw_refused;
         auth_refused <= next_auth_refused;
         fuse_done <= next_fuse_done;
         fuse_rejected <= next_fuse_rejected;
         read_grant <= next_read_grant;
         write_grant <= next_write_grant;
         security_fuse_status <= {slf_pkg::FUSE_RESV, next_fuses};
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         password_fail_counter <= '{default: slf_pkg::CNT_FULL};
         auth_fail_counter <= '{default: slf_pkg::CNT_FULL};
      end else begin
         password_fail_counter <= pw_cnt;
         auth_fail_counter <= key_cnt;
      end
   end
endmodule

/* File: slf_chk.sv */
/* Checker on the ports of slf_security_core.
   Assumes one clock and an async active-high reset; bound from the bench. */
`timescale 1ns/1ps
module slf_chk (
   // Clock, reset and requests
   input wire logic sys_clk, sys_rst, nv_load, pw_verify, pw_match, auth_verify, auth_match,
   input wire logic fuse_req, acc_zone_read_ok, acc_zone_write_ok,
   input wire logic [3:0] pw_index, acc_area,
   input wire logic [1:0] auth_key, fuse_id,
   // Results
   input wire logic pw_refused, fuse_done, fuse_rejected, read_grant, write_grant,
   input wire logic [7:0] security_fuse_status,
   input wire logic [7:0] password_fail_counter [16],
   input wire logic [7:0] auth_fail_counter [4]
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   function automatic logic [7:0] nxt(input logic [7:0] c, input logic ok);
      nxt = ok ? 8'hff : {c[6:4], 1'b0, c[2:0], 1'b0};
   endfunction
   ////////////////////////////////////////////////////////////////////////
   // No verify or load in the two cycles before, so counter copies are current
   sequence s_quiet;
      !$past(pw_verify) && !$past(pw_verify, 2) && !$past(auth_verify)
         && !$past(auth_verify, 2) && !$past(nv_load) && !$past(nv_load, 2);
   endsequence
   property p_pw_step;
      s_quiet ##0 (pw_verify && password_fail_counter[pw_index] != 8'h00) |-> ##2
         password_fail_counter[$past(pw_index, 2)]
         == nxt($past(password_fail_counter[pw_index], 2), $past(pw_match, 2));
   endproperty
   a_pw_step: assert property (p_pw_step) else $error("password counter step");
   property p_pw_lock;
      s_quiet ##0 (pw_verify && password_fail_counter[pw_index] == 8'h00) |=>
         pw_refused ##1 password_fail_counter[$past(pw_index, 2)] == 8'h00;
   endproperty
   a_pw_lock: assert property (p_pw_lock) else $error("locked password used");
   property p_auth_step;
      s_quiet ##0 (auth_verify && auth_fail_counter[auth_key] != 8'h00) |-> ##2
         auth_fail_counter[$past(auth_key, 2)]
         == nxt($past(auth_fail_counter[auth_key], 2), $past(auth_match, 2));
   endproperty
   a_auth_step: assert property (p_auth_step) else $error("key counter step");
   property p_fab;
      fuse_req && fuse_id == 2'h0 && security_fuse_status[0] && !nv_load |=>
         fuse_done && security_fuse_status[3:0] == ($past(security_fuse_status[3:0]) & 4'he);
   endproperty
   a_fab: assert property (p_fab) else $error("fab fuse blow");
   property p_order;
      fuse_req && !nv_load && (fuse_id == 2'h3
         || fuse_id != 2'h0 && security_fuse_status[fuse_id - 2'h1])
         |=> fuse_rejected && $stable(security_fuse_status);
   endproperty
   a_order: assert property (p_order) else $error("fuse out of order");
   property p_oneway;
      (security_fuse_status[3:0] & ~$past(security_fuse_status[3:0])) == 4'h0;
   endproperty
   a_oneway: assert property (p_oneway) else $error("fuse restored");
   property p_user;
      acc_area == slf_pkg::AREA_USER |=> read_grant == $past(acc_zone_read_ok)
         && write_grant == $past(acc_zone_write_ok);
   endproperty
   a_user: assert property (p_user) else $error("user zone grant");
   property p_pers;
      !security_fuse_status[slf_pkg::FUSE_PERS] && (acc_area == slf_pkg::AREA_SECRET
         || acc_area == slf_pkg::AREA_SESSION) |=> !read_grant && !write_grant;
   endproperty
   a_pers: assert property (p_pers) else $error("secret after lock");
endmodule

/* File: slf_host.sv */
/* Host model: one-cycle verify, fuse, load and query requests.
   Assumes the bench calls send; inputs change on falling edges. */
`timescale 1ns/1ps
module slf_host (
   // Clock
   input wire logic sys_clk,
   // Requests
   output logic nv_load, pw_verify, pw_match, auth_verify, auth_match, fuse_req,
   output logic acc_zone_read_ok, acc_zone_write_ok,
   output logic [3:0] nv_fuses, pw_index, acc_area,
   output logic [1:0] auth_key, fuse_id,
   output logic [2:0] acc_pw_set,
   output logic [127:0] nv_pw_counts,
   output logic [31:0] nv_key_counts
);
   initial begin
      {nv_load, pw_verify, pw_match, auth_verify, auth_match, fuse_req} = 6'h0;
      {acc_zone_read_ok, acc_zone_write_ok, nv_fuses, pw_index, acc_area} = 14'h0;
      {auth_key, fuse_id, acc_pw_set} = 7'h0;
      nv_pw_counts = '1;
      nv_key_counts = '1;
   end
   // Kind 0 password, 1 key, 2 fuse (bench picks the order), 3 load, 4 query
   task automatic send(input logic [2:0] kind, input logic [3:0] idx, input logic ok);
      @(negedge sys_clk);
      pw_index = idx;
      auth_key = idx[1:0];
      fuse_id = idx[1:0];
      acc_area = idx;
      acc_pw_set = idx[2:0];
      nv_fuses = idx;
      pw_match = ok;
      auth_match = ok;
      acc_zone_read_ok = ok;
      acc_zone_write_ok = !ok;
      {nv_load, fuse_req, auth_verify, pw_verify} = 4'h1 << kind;
      @(negedge sys_clk);
      {nv_load, fuse_req, auth_verify, pw_verify} = 4'h0;
   endtask
endmodule

/* File: security_lockout_and_fuses_bench.sv */
/* Bench for slf_security_core driven through the host model.
   Assumes nothing else; ends with one verdict line. */
`timescale 1ns/1ps
module security_lockout_and_fuses_bench;
   logic sys_clk, sys_rst, nv_load, pw_verify, pw_match, auth_verify, auth_match, fuse_req;
   logic acc_zone_read_ok, acc_zone_write_ok, pw_refused, auth_refused, fuse_done;
   logic fuse_rejected, read_grant, write_grant;
   logic [3:0] nv_fuses, pw_index, acc_area;
   logic [1:0] auth_key, fuse_id;
   logic [2:0] acc_pw_set;
   logic [127:0] nv_pw_counts;
   logic [31:0] nv_key_counts;
   logic [7:0] security_fuse_status;
   logic [7:0] password_fail_counter [16];
   logic [7:0] auth_fail_counter [4];
   int err_count = 0;
   int n_checks = 0;
   int fails [20] = '{default: 0};
   slf_host slf_host_inst (.*);
   slf_security_core slf_security_core_inst (.*);
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Expected counter after n failures in a row
   function automatic logic [7:0] cnt(input int n);
      cnt = {2{4'(4'hf << n)}};
   endfunction
   task automatic try(input logic key, input int i, input logic ok);
      int j;
      j = key ? i + 16 : i;
      slf_host_inst.send({2'h0, key}, 4'(i), ok);
      chk({7'h0, key ? auth_refused : pw_refused}, {7'h0, fails[j] > 3});
      fails[j] = fails[j] > 3 ? 4 : (ok ? 0 : fails[j] + 1);
      repeat (2) @(negedge sys_clk);
      chk(key ? auth_fail_counter[i] : password_fail_counter[i], cnt(fails[j]));
   endtask
   task automatic ask(input logic [3:0] area, input logic ok, input logic r, input logic w);
      slf_host_inst.send(3'h4, area, ok);
      chk({6'h0, read_grant, write_grant}, {6'h0, r, w});
   endtask
   task automatic blow(input logic [1:0] id, input logic ok, input logic [7:0] st);
      slf_host_inst.send(3'h2, {2'h0, id}, 1'b0);
      chk({6'h0, fuse_done, fuse_rejected}, {6'h0, ok, !ok});
      chk(security_fuse_status, st);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'hbc8ae391));
      sys_rst = 1'b1;
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      sys_rst = 1'b0;
      slf_host_inst.send(3'h3, 4'h7, 1'b0);
      chk(security_fuse_status, 8'hf7);
      ask(slf_pkg::AREA_LOT, 1'b1, 1'b1, 1'b0);
      ask(slf_pkg::AREA_SECRET, 1'b1, 1'b0, 1'b0);
      try(1'b0, 7, 1'b1);
      ask(slf_pkg::AREA_SECRET, 1'b1, 1'b1, 1'b1);
      blow(2'h1, 1'b0, 8'hf7);
      blow(2'h2, 1'b0, 8'hf7);
      blow(2'h0, 1'b1, 8'hf6);
      ask(slf_pkg::AREA_IDENT, 1'b1, 1'b1, 1'b0);
      ask(slf_pkg::AREA_MAKER, 1'b1, 1'b1, 1'b1);
      ask(slf_pkg::AREA_RESET_ANS, 1'b1, 1'b1, 1'b0);
      blow(2'h2, 1'b0, 8'hf6);
      blow(2'h1, 1'b1, 8'hf4);
      ask(slf_pkg::AREA_MAKER, 1'b1, 1'b1, 1'b0);
      ask(slf_pkg::AREA_ACCESS, 1'b1, 1'b1, 1'b1);
      blow(2'h3, 1'b0, 8'hf4);
      blow(2'h2, 1'b1, 8'hf0);
      ask(slf_pkg::AREA_ACCESS, 1'b1, 1'b1, 1'b0);
      ask(slf_pkg::AREA_SESSION, 1'b1, 1'b0, 1'b0);
      ask(slf_pkg::AREA_FORBID, 1'b1, 1'b0, 1'b0);
      ask(slf_pkg::AREA_TEST, 1'b1, 1'b1, 1'b1);
      ask(slf_pkg::AREA_PASSWORD, 1'b1, 1'b0, 1'b0);
      try(1'b0, 0, 1'b1);
      ask(slf_pkg::AREA_PASSWORD, 1'b1, 1'b1, 1'b1);
      ask(slf_pkg::AREA_PW_CNT, 1'b1, 1'b1, 1'b0);
      for (int n = 0; n < 6; n++) begin
         try(1'b0, 3, n == 5);
         try(1'b1, 2, n == 5);
      end
      for (int n = 0; n < 60; n++) begin
         int j;
         logic ok;
         j = $urandom % 20;
         ok = ($urandom % 3) == 0;
         try(j > 15, j > 15 ? j - 16 : j, ok);
         ask(slf_pkg::AREA_USER, ok, ok, !ok);
      end
      slf_host_inst.send(3'h3, 4'hf, 1'b0);
      chk(security_fuse_status, 8'hf0);
      stop_test();
   end
   initial begin
      #2000000;
      err_count++;
      stop_test();
   end
endmodule
bind slf_security_core slf_chk slf_chk_inst (.*);
